//--- src/tap_port.v
// Contract
// - All scan state and data move only on edges of the test clock, or on test or system reset.
// - Test data in is captured on the rising test-clock edge while shifting.
// - Test data out changes on the falling test-clock edge while shifting.
// - Mode select sampled at each rising edge picks the next port state.
// - Test reset puts the port controller into reset two system clocks late, no test clock edge needed.
// - Test data out is driven only in Shift-DR and Shift-IR, else floated.
//
// Purpose: boundary-scan test access port controller with IR and DR paths
// Assumes: test pins are asynchronous and sampled by the 20 MHz clock
// Notes: test reset acts on the synchronised level without a test clock edge
`timescale 1ns/1ps
`include "tap_port_consts.vh"
module tap_port #(
  parameter IR_W = `IR_WIDTH,
  parameter DR_W = `DR_WIDTH
) (
  input wire i_sys_clk,
  input wire i_reset_n,
  input wire i_tck,
  input wire i_tms,
  input wire i_tdi,
  input wire i_trst_n,
  input wire [DR_W-1:0] i_dr_capture,
  output reg o_tdo,
  output reg o_tdo_oe,
  output reg [IR_W-1:0] o_instr,
  output reg [DR_W-1:0] o_dr_update,
  output reg o_dr_update_strobe,
  output reg o_test_reset
);
  // ------------------------------------------------------------
  // Pin synchronisers
  // ------------------------------------------------------------
  wire tck_rise;
  wire tck_fall;
  wire tms_s;
  wire tdi_s;
  wire trst_s_n;
  reg tms_m_reg;
  reg tms_reg;
  reg tdi_m_reg;
  reg tdi_reg;
  reg trst_m_reg;
  reg trst_reg;

  tap_edge_sync u_tck_sync (
    .i_sys_clk(i_sys_clk),
    .i_reset_n(i_reset_n),
    .i_pin(i_tck),
    .o_level(),
    .o_rise(tck_rise),
    .o_fall(tck_fall)
  );

  // Mode select and data in rest high, the level their pins idle at
  // Test reset reaches the controller two system clocks late; no test
  // clock edge is needed, so a stopped test clock cannot block it
  always @(posedge i_sys_clk) begin
    if (!i_reset_n) begin
      tms_m_reg <= 1'b1;
      tms_reg <= 1'b1;
      tdi_m_reg <= 1'b1;
      tdi_reg <= 1'b1;
      trst_m_reg <= 1'b0;
      trst_reg <= 1'b0;
    end else begin
      tms_m_reg <= i_tms;
      tms_reg <= tms_m_reg;
      tdi_m_reg <= i_tdi;
      tdi_reg <= tdi_m_reg;
      trst_m_reg <= i_trst_n;
      trst_reg <= trst_m_reg;
    end
  end

  assign tms_s = tms_reg;
  assign tdi_s = tdi_reg;
  assign trst_s_n = trst_reg;

  // ------------------------------------------------------------
  // Next-state function of the port controller
  // ------------------------------------------------------------
  function [3:0] next_state;
    input [3:0] st;
    input tms;
    begin
      case (st)
        `ST_RESET: next_state = tms ? `ST_RESET : `ST_IDLE;
        `ST_IDLE: next_state = tms ? `ST_SEL_DR : `ST_IDLE;
        `ST_SEL_DR: next_state = tms ? `ST_SEL_IR : `ST_CAP_DR;
        `ST_CAP_DR: next_state = tms ? `ST_EXIT1_DR : `ST_SHIFT_DR;
        `ST_SHIFT_DR: next_state = tms ? `ST_EXIT1_DR : `ST_SHIFT_DR;
        `ST_EXIT1_DR: next_state = tms ? `ST_UPD_DR : `ST_PAUSE_DR;
        `ST_PAUSE_DR: next_state = tms ? `ST_EXIT2_DR : `ST_PAUSE_DR;
        `ST_EXIT2_DR: next_state = tms ? `ST_UPD_DR : `ST_SHIFT_DR;
        `ST_UPD_DR: next_state = tms ? `ST_SEL_DR : `ST_IDLE;
        `ST_SEL_IR: next_state = tms ? `ST_RESET : `ST_CAP_IR;
        `ST_CAP_IR: next_state = tms ? `ST_EXIT1_IR : `ST_SHIFT_IR;
        `ST_SHIFT_IR: next_state = tms ? `ST_EXIT1_IR : `ST_SHIFT_IR;
        `ST_EXIT1_IR: next_state = tms ? `ST_UPD_IR : `ST_PAUSE_IR;
        `ST_PAUSE_IR: next_state = tms ? `ST_EXIT2_IR : `ST_PAUSE_IR;
        `ST_EXIT2_IR: next_state = tms ? `ST_UPD_IR : `ST_SHIFT_IR;
        `ST_UPD_IR: next_state = tms ? `ST_SEL_DR : `ST_IDLE;
        default: next_state = `ST_RESET;
      endcase
    end
  endfunction

  // ------------------------------------------------------------
  // State and instruction decodes
  // ------------------------------------------------------------
  function is_shift;
    input [3:0] st;
    begin
      is_shift = (st == `ST_SHIFT_DR) || (st == `ST_SHIFT_IR);
    end
  endfunction

  function is_bypass;
    input [IR_W-1:0] ins;
    begin
      is_bypass = (ins == `IR_BYPASS);
    end
  endfunction

  // Bit presented at a falling test clock edge in a shift state
  function shift_out_bit;
    input [3:0] st;
    input ir_lsb;
    input dr_lsb;
    input byp;
    input use_byp;
    begin
      case (st)
        `ST_SHIFT_IR: shift_out_bit = ir_lsb;
        `ST_SHIFT_DR: shift_out_bit = use_byp ? byp : dr_lsb;
        default: shift_out_bit = 1'b0;
      endcase
    end
  endfunction

  // ------------------------------------------------------------
  // Controller and shift registers
  // ------------------------------------------------------------
  reg [3:0] state_reg;
  reg [IR_W-1:0] ir_shift_reg;
  reg [DR_W-1:0] dr_shift_reg;
  reg bypass_reg;
  wire sel_bypass;

  assign sel_bypass = is_bypass(o_instr);

  always @(posedge i_sys_clk) begin
    if (!i_reset_n || !trst_s_n) begin
      state_reg <= `ST_RESET;
      ir_shift_reg <= {IR_W{1'b0}};
      dr_shift_reg <= `DR_RESET;
      bypass_reg <= 1'b0;
      o_instr <= `IR_BYPASS;
      o_dr_update <= `DR_RESET;
      o_dr_update_strobe <= 1'b0;
      o_test_reset <= 1'b1;
    end else begin
      o_dr_update_strobe <= 1'b0;
      o_test_reset <= (state_reg == `ST_RESET);
      if (tck_rise) begin
        state_reg <= next_state(state_reg, tms_s);
        case (state_reg)
          `ST_RESET: begin
            o_instr <= `IR_BYPASS;
          end
          `ST_CAP_IR: begin
            ir_shift_reg <= `IR_CAPTURE;
          end
          `ST_SHIFT_IR: begin
            ir_shift_reg <= {tdi_s, ir_shift_reg[IR_W-1:1]};
          end
          `ST_UPD_IR: begin
            o_instr <= ir_shift_reg;
          end
          `ST_CAP_DR: begin
            dr_shift_reg <= i_dr_capture;
            bypass_reg <= 1'b0;
          end
          `ST_SHIFT_DR: begin
            dr_shift_reg <= {tdi_s, dr_shift_reg[DR_W-1:1]};
            bypass_reg <= tdi_s;
          end
          `ST_UPD_DR: begin
            if (!sel_bypass) begin
              o_dr_update <= dr_shift_reg;
              o_dr_update_strobe <= 1'b1;
            end
          end
          default: begin
          end
        endcase
      end
    end
  end

  // ------------------------------------------------------------
  // Test data out on the falling edge
  // ------------------------------------------------------------
  always @(posedge i_sys_clk) begin
    if (!i_reset_n || !trst_s_n) begin
      o_tdo <= 1'b0;
      o_tdo_oe <= 1'b0;
    end else if (tck_fall) begin
      // The enable follows the state so the pin floats outside shifting
      o_tdo_oe <= is_shift(state_reg);
      if (is_shift(state_reg)) begin
        o_tdo <= shift_out_bit(state_reg, ir_shift_reg[0],
                               dr_shift_reg[0], bypass_reg, sel_bypass);
      end
    end
  end
endmodule

//--- src/tap_port_consts.vh
// Purpose: constants for the boundary-scan test access port
// Assumes: 20 MHz system clock, test clock far slower
// Notes: port states use the customary four-bit codes
`ifndef TAP_PORT_CONSTS_VH
`define TAP_PORT_CONSTS_VH

// ------------------------------------------------------------
// Port controller state codes
// ------------------------------------------------------------
`define ST_RESET      4'h0
`define ST_IDLE       4'h1
`define ST_SEL_DR     4'h2
`define ST_CAP_DR     4'h3
`define ST_SHIFT_DR   4'h4
`define ST_EXIT1_DR   4'h5
`define ST_PAUSE_DR   4'h6
`define ST_EXIT2_DR   4'h7
`define ST_UPD_DR     4'h8
`define ST_SEL_IR     4'h9
`define ST_CAP_IR     4'hA
`define ST_SHIFT_IR   4'hB
`define ST_EXIT1_IR   4'hC
`define ST_PAUSE_IR   4'hD
`define ST_EXIT2_IR   4'hE
`define ST_UPD_IR     4'hF

// ------------------------------------------------------------
// Instruction and data registers
// ------------------------------------------------------------
`define IR_WIDTH      4
`define IR_BYPASS     4'hF
`define IR_CAPTURE    4'h1
`define DR_WIDTH      32
`define DR_RESET      32'h0000_0000

`endif

//--- src/tap_edge_sync.v
// Purpose: synchronise a pin and report its rising and falling edges
// Assumes: pin input is asynchronous to the system clock
// Notes: first flop is read only by the second flop
`timescale 1ns/1ps
module tap_edge_sync (
  input wire i_sys_clk,
  input wire i_reset_n,
  input wire i_pin,
  output reg o_level,
  output wire o_rise,
  output wire o_fall
);
  reg meta_reg;
  reg last_reg;

  always @(posedge i_sys_clk) begin
    if (!i_reset_n) begin
      meta_reg <= 1'b0;
      o_level <= 1'b0;
      last_reg <= 1'b0;
    end else begin
      meta_reg <= i_pin;
      o_level <= meta_reg;
      last_reg <= o_level;
    end
  end

  assign o_rise = o_level & ~last_reg;
  assign o_fall = ~o_level & last_reg;
endmodule

//--- dv/tap_port_properties.sv
// Purpose: timing checks on the test access port
// Assumes: 50 ns system clock, test pins far slower
// Notes: bound into every tap_port
`timescale 1ns/1ps
`include "tap_port_consts.vh"
module tap_port_properties #(parameter IR_W = 4, parameter DR_W = 32) (
  input wire i_sys_clk,
  input wire i_reset_n,
  input wire i_tck,
  input wire i_tms,
  input wire i_tdi,
  input wire i_trst_n,
  input wire [DR_W-1:0] i_dr_capture,
  input wire o_tdo,
  input wire o_tdo_oe,
  input wire [IR_W-1:0] o_instr,
  input wire [DR_W-1:0] o_dr_update,
  input wire o_dr_update_strobe,
  input wire o_test_reset
);
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (!i_reset_n);
  reg [2:0] hi_cnt_reg;
  // Test clock rises seen while mode select stays high
  always @(posedge i_sys_clk)
    if (!i_reset_n || !i_tms) hi_cnt_reg <= 3'h0;
    else if ($rose(i_tck) && hi_cnt_reg != 3'h7)
      hi_cnt_reg <= hi_cnt_reg + 3'h1;
  sequence s_five_high;
    hi_cnt_reg == 3'h5 && $past(hi_cnt_reg) == 3'h4;
  endsequence
  AST_FIVE_HIGH: assert property (s_five_high |-> ##6 o_test_reset)
    else $error("no reset after five highs");
  AST_TRST_NOW: assert property (!i_trst_n [*5] |-> o_test_reset)
    else $error("test reset ignored");
  AST_TDO_FALL: assert property ($changed(o_tdo) |-> !$past(i_tck, 2))
    else $error("tdo moved off a fall");
  AST_OE_FALL: assert property ($changed(o_tdo_oe) |-> !$past(i_tck, 2))
    else $error("enable moved off a fall");
  AST_INSTR_RISE: assert property ($changed(o_instr) && i_trst_n |->
    $past(i_tck, 2)) else $error("instruction moved off a rise");
  AST_DR_RISE: assert property ($changed(o_dr_update) && i_trst_n |->
    $past(i_tck, 2)) else $error("update moved off a rise");
  AST_STROBE: assert property (o_dr_update_strobe |->
    o_instr != `IR_BYPASS ##1 !o_dr_update_strobe) else $error("bad strobe");
endmodule
bind tap_port tap_port_properties #(.IR_W(IR_W), .DR_W(DR_W)) u_props (.*);

//--- dv/tap_ctrl_model.sv
// Purpose: external test controller model
// Assumes: pins move on system clock falls
// Notes: test clock stands low between steps
`timescale 1ns/1ps
module tap_ctrl_model (
  input wire i_sys_clk,
  input wire i_tdo,
  input wire i_tdo_oe,
  output reg o_tck = 1'b0,
  output reg o_tms = 1'b1,
  output reg o_tdi = 1'b0,
  output reg o_trst_n = 1'b1
);
  reg last_reg = 1'b0;
  // A floated line shows a changing pattern
  wire tdo_line = i_tdo_oe ? i_tdo : ~last_reg;
  always @(posedge i_sys_clk) last_reg <= tdo_line;
  task step(input t, input d, output q);
    o_tms = t;
    o_tdi = d;
    repeat (4) @(negedge i_sys_clk);
    o_tck = 1'b1;
    repeat (2) @(negedge i_sys_clk);
    q = tdo_line;
    repeat (2) @(negedge i_sys_clk);
    o_tck = 1'b0;
  endtask
  task pulse_reset;
    o_trst_n = 1'b0;
    repeat (6) @(negedge i_sys_clk);
    o_trst_n = 1'b1;
  endtask
endmodule

//--- dv/tb.sv
// Purpose: self-checking bench for tap_port
// Assumes: 50 ns system clock, 400 ns test clock
// Notes: expected serial bits held in a queue
`timescale 1ns/1ps
`include "tap_port_consts.vh"
module tb;
  reg clk = 1'b0;
  reg rst_n = 1'b0;
  reg [31:0] cap = 32'h0000_0000;
  reg [19:0] seed = 20'h1_6340;
  reg [31:0] din;
  reg q;
  wire tck, tms, tdi, trst_n, tdo, oe, strobe, test_rst;
  wire [3:0] instr;
  wire [31:0] dr_upd;
  integer err_total = 0;
  integer n_compared = 0;
  integer n_strobe = 0;
  integer i;
  bit exp_q[$];
  always #25 clk = ~clk;
  always @(posedge clk) if (strobe) n_strobe <= n_strobe + 1;
  tap_ctrl_model u_ctrl (.i_sys_clk(clk), .i_tdo(tdo), .i_tdo_oe(oe),
    .o_tck(tck), .o_tms(tms), .o_tdi(tdi), .o_trst_n(trst_n));
  tap_port u_dut (.i_sys_clk(clk), .i_reset_n(rst_n), .i_tck(tck),
    .i_tms(tms), .i_tdi(tdi), .i_trst_n(trst_n), .i_dr_capture(cap),
    .o_tdo(tdo), .o_tdo_oe(oe), .o_instr(instr), .o_dr_update(dr_upd),
    .o_dr_update_strobe(strobe), .o_test_reset(test_rst));
  function [19:0] lfsr(input [19:0] s);
    lfsr = {s[18:0], s[19] ^ s[16]};
  endfunction
  task chk(input [31:0] seen, input [31:0] exp);
    n_compared = n_compared + 1;
    if (seen !== exp) begin
      err_total = err_total + 1;
      $display("BAD %0t seen %h want %h", $time, seen, exp);
    end
  endtask
  task load(input integer n, input [31:0] v);
    for (i = 0; i < n; i = i + 1) exp_q.push_back(v[i]);
  endtask
  task scan(input integer n, input [31:0] t, input [31:0] d);
    for (i = 0; i < n; i = i + 1) begin
      u_ctrl.step(t[i], d[i], q);
      chk(oe, exp_q.size() != 0);
      if (exp_q.size() != 0) chk(q, exp_q.pop_front());
    end
  endtask
  task results;
    $display("compared %0d mismatched %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  initial begin
    repeat (6) @(negedge clk);
    rst_n = 1'b1;
    repeat (4) @(negedge clk);
    chk({instr, test_rst, oe}, {`IR_BYPASS, 2'b10});
    seed = lfsr(seed);
    din = {28'h0, seed[3:0] & 4'hE};
    scan(5, 32'h0000_0006, 0);
    load(4, `IR_CAPTURE);
    scan(4, 32'h0000_0008, din);
    scan(2, 32'h0000_0001, 0);
    chk(instr, din);
    $display("ir scan done");
    seed = lfsr(seed);
    cap = {seed, seed[11:0]};
    din = ~cap;
    scan(3, 32'h0000_0001, 0);
    load(32, cap);
    scan(32, 32'h8000_0000, din);
    scan(2, 32'h0000_0001, 0);
    chk(dr_upd, din);
    chk(n_strobe, 1);
    $display("dr scan done");
    u_ctrl.pulse_reset();
    chk({instr, test_rst}, {`IR_BYPASS, 1'b1});
    scan(4, 32'h0000_0002, 0);
    chk(test_rst, 0);
    load(1, 0);
    scan(5, 32'h0000_001F, 0);
    repeat (4) @(negedge clk);
    chk(test_rst, 1);
    chk(n_strobe, 1);
    $display("reset tests done");
    results;
  end
  initial begin
    #100000;
    err_total = err_total + 1;
    results;
  end
endmodule
